//--- pkg/acps_params.svh
// timing constants and register map of the amplifier control-pin sequencer
`ifndef ACPS_PARAMS_SVH
`define ACPS_PARAMS_SVH
`define ACPS_CLK_MHZ 125
`define ACPS_RST_VALID_NS 300
`define ACPS_RST_VALID_CYC ((`ACPS_RST_VALID_NS * `ACPS_CLK_MHZ) / 1000)
`define ACPS_RUN_MS 10
`define ACPS_RUN_CYC (`ACPS_RUN_MS * `ACPS_CLK_MHZ * 1000)
`define ACPS_PDN_VALID_US 725
`define ACPS_PDN_VALID_CYC (`ACPS_PDN_VALID_US * `ACPS_CLK_MHZ)
`define ACPS_STARTUP_MS 120
`define ACPS_STARTUP_CYC (`ACPS_STARTUP_MS * `ACPS_CLK_MHZ * 1000)
`define ACPS_FAULT_NS 350
`define ACPS_FAULT_CYC ((`ACPS_FAULT_NS * `ACPS_CLK_MHZ) / 1000)
`define ACPS_MS_CYC (`ACPS_CLK_MHZ * 1000)
`define ACPS_SW_MIN_US 200
`define ACPS_SW_MIN_CYC ((`ACPS_SW_MIN_US * `ACPS_CLK_MHZ + 999) / 1000)
`define ACPS_ADDR_W 8
`define ACPS_REG_CTRL 8'h00
`define ACPS_REG_HOLD 8'h1c
`define ACPS_REG_RAMP 8'h20
`define ACPS_REG_HPCFG 8'h24
`define ACPS_REG_STAT 8'h28
`define ACPS_HOLD_RST 8'h01
`define ACPS_RAMP_RST 16'h0400
`define ACPS_HP_DIS_BIT 4
`define ACPS_STEP_NORMAL 8'h04
`define ACPS_STEP_DOUBLE 8'h08
`define ACPS_STEP_QUAD 8'h10
`endif

//--- pkg/acps_pkg.sv
// types of the amplifier control-pin sequencer
package acps_pkg;
    typedef enum logic [1:0] {ACPS_FS_NORMAL, ACPS_FS_DOUBLE, ACPS_FS_QUAD} acps_rate_t;
    typedef enum logic [2:0] {ACPS_RESET, ACPS_IDLE, ACPS_WAIT_RUN, ACPS_RUN, ACPS_PDN_DRAIN, ACPS_DOWN,
        ACPS_STARTUP} acps_state_t;
endpackage : acps_pkg

//--- core/acps_sync.sv
// two-flop synchroniser for one control pin
`timescale 1ns/100ps
module acps_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // pin and synchronised level
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_q;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            meta_q <= RESET_VAL;
            pin_sync <= RESET_VAL;
        end else begin
            meta_q <= pin_in;
            pin_sync <= meta_q;
        end
    end
endmodule : acps_sync

//--- core/acps_top.sv
// control-pin sequencer: reset, power-down, fault recovery, soft mute ramp, headphone switch-over
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "acps_params.svh"
module acps_top #(
    parameter int RUN_CYC = `ACPS_RUN_CYC,
    parameter int PDN_VALID_CYC = `ACPS_PDN_VALID_CYC,
    parameter int STARTUP_CYC = `ACPS_STARTUP_CYC,
    parameter int MS_CYC = `ACPS_MS_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // control pins
    input wire logic device_reset_n,
    input wire logic power_down_in_n,
    input wire logic backend_fault_n,
    input wire logic headphone_select,
    input wire logic mute,
    input wire logic frame_clk,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // power stage and outputs
    output logic power_stage_en,
    output logic bridge_out_en,
    output logic headphone_modulator_out,
    output logic speaker_path_sel,
    output logic [15:0] volume_level
);
    logic rst_s, pdn_s, flt_s, hp_s, fr_s, fr_q;
    // pins sampled on the core clock; on reset the reset pin reads asserted, the other pins idle
    acps_sync #(.RESET_VAL(1'b0)) u_sync_rst (.clk_sys(clk_sys), .rstn(rstn), .pin_in(device_reset_n),
        .pin_sync(rst_s));
    acps_sync #(.RESET_VAL(1'b1)) u_sync_pdn (.clk_sys(clk_sys), .rstn(rstn), .pin_in(power_down_in_n),
        .pin_sync(pdn_s));
    acps_sync #(.RESET_VAL(1'b1)) u_sync_flt (.clk_sys(clk_sys), .rstn(rstn), .pin_in(backend_fault_n),
        .pin_sync(flt_s));
    acps_sync #(.RESET_VAL(1'b0)) u_sync_hp (.clk_sys(clk_sys), .rstn(rstn), .pin_in(headphone_select),
        .pin_sync(hp_s));
    acps_sync #(.RESET_VAL(1'b0)) u_sync_fr (.clk_sys(clk_sys), .rstn(rstn), .pin_in(frame_clk),
        .pin_sync(fr_s));

    // registers
    logic start_cmd_q;
    logic [1:0] rate_q;
    logic [7:0] hold_ms_q;
    logic [15:0] ramp_steps_q;
    logic hp_dis_q;
    wire wr_ctrl = reg_wr && (reg_addr == `ACPS_REG_CTRL);
    wire wr_hold = reg_wr && (reg_addr == `ACPS_REG_HOLD);
    wire wr_ramp = reg_wr && (reg_addr == `ACPS_REG_RAMP);
    wire wr_hp = reg_wr && (reg_addr == `ACPS_REG_HPCFG);
    wire start_req = wr_ctrl && reg_wdata[0];

    // sequencer
    acps_pkg::acps_state_t st_q, st_d;
    logic [31:0] tmr_q;
    wire tmr_zero = (tmr_q == 32'h0);
    wire rst_act = !rst_s;
    wire pdn_act = !pdn_s;
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            acps_pkg::ACPS_RESET: if (!rst_act) st_d = acps_pkg::ACPS_IDLE;
            acps_pkg::ACPS_IDLE: begin
                if (rst_act) st_d = acps_pkg::ACPS_RESET;
                else if (pdn_act) st_d = acps_pkg::ACPS_PDN_DRAIN;
                else if (start_cmd_q) st_d = acps_pkg::ACPS_WAIT_RUN;
            end
            acps_pkg::ACPS_WAIT_RUN: begin
                if (rst_act) st_d = acps_pkg::ACPS_RESET;
                else if (pdn_act) st_d = acps_pkg::ACPS_PDN_DRAIN;
                else if (tmr_zero) st_d = acps_pkg::ACPS_RUN;
            end
            acps_pkg::ACPS_RUN: begin
                if (rst_act) st_d = acps_pkg::ACPS_RESET;
                else if (pdn_act) st_d = acps_pkg::ACPS_PDN_DRAIN;
            end
            acps_pkg::ACPS_PDN_DRAIN: begin
                if (!pdn_act) st_d = acps_pkg::ACPS_STARTUP;
                else if (tmr_zero) st_d = acps_pkg::ACPS_DOWN;
            end
            // reset pin is not looked at while powered down
            acps_pkg::ACPS_DOWN: if (!pdn_act) st_d = acps_pkg::ACPS_STARTUP;
            acps_pkg::ACPS_STARTUP: begin
                if (pdn_act) st_d = acps_pkg::ACPS_PDN_DRAIN;
                else if (tmr_zero) st_d = acps_pkg::ACPS_RUN;
            end
            default: st_d = acps_pkg::ACPS_RESET;
        endcase
    end
    wire enter = (st_d != st_q);
    logic [31:0] tmr_load;
    assign tmr_load = (st_d == acps_pkg::ACPS_WAIT_RUN) ? 32'(RUN_CYC) :
                      (st_d == acps_pkg::ACPS_PDN_DRAIN) ? 32'(PDN_VALID_CYC) :
                      (st_d == acps_pkg::ACPS_STARTUP) ? 32'(STARTUP_CYC) : 32'h0;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q <= acps_pkg::ACPS_RESET;
            tmr_q <= 32'h0;
        end else begin
            st_q <= st_d;
            tmr_q <= enter ? tmr_load : (tmr_zero ? tmr_q : tmr_q - 32'h1);
        end
    end

    // start command latched until consumed; reset clears it
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            start_cmd_q <= 1'b0;
        end else if (start_req) begin
            start_cmd_q <= 1'b1;
        end else if (st_q != acps_pkg::ACPS_IDLE) begin
            start_cmd_q <= 1'b0;
        end
    end

    // fault hold: bridge low while hold runs, recovery only with fault released
    logic flt_hold_q;
    logic [7:0] hold_left_q;
    logic [31:0] ms_cnt_q;
    wire ms_tick = (ms_cnt_q == 32'h0);
    wire hold_done = flt_hold_q && (hold_left_q == 8'h0);
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            flt_hold_q <= 1'b0;
            hold_left_q <= 8'h0;
            ms_cnt_q <= 32'h0;
        end else if (!flt_s) begin
            flt_hold_q <= 1'b1;
            hold_left_q <= hold_ms_q;
            ms_cnt_q <= 32'(MS_CYC - 1);
        end else if (flt_hold_q) begin
            ms_cnt_q <= ms_tick ? 32'(MS_CYC - 1) : ms_cnt_q - 32'h1;
            if (hold_done) flt_hold_q <= 1'b0;
            else if (ms_tick) hold_left_q <= hold_left_q - 8'h1;
        end
    end

    // soft ramp on frame clock edges
    logic [7:0] step_len;
    assign step_len = (rate_q == 2'(acps_pkg::ACPS_FS_QUAD)) ? `ACPS_STEP_QUAD :
                      (rate_q == 2'(acps_pkg::ACPS_FS_DOUBLE)) ? `ACPS_STEP_DOUBLE : `ACPS_STEP_NORMAL;
    wire fr_rise = fr_s && !fr_q;
    logic [7:0] fr_cnt_q;
    // at or above the last count so a rate change to a shorter step never strands the counter
    wire step_tick = fr_rise && (fr_cnt_q >= step_len - 8'h1);
    logic hp_q, hp_busy_q;
    wire hp_chg = (hp_s != hp_q);
    wire ramp_down = mute || hp_busy_q;
    wire at_target = ramp_down ? (volume_level == 16'h0) : (volume_level == ramp_steps_q);
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            fr_q <= 1'b0;
            fr_cnt_q <= 8'h0;
            volume_level <= 16'h0;
        end else begin
            fr_q <= fr_s;
            if (fr_rise) fr_cnt_q <= step_tick ? 8'h0 : fr_cnt_q + 8'h1;
            if (volume_level > ramp_steps_q) volume_level <= ramp_steps_q;
            else if (step_tick && !at_target)
                volume_level <= ramp_down ? volume_level - 16'h1 : volume_level + 16'h1;
        end
    end

    // headphone switch-over: ramp down, then 0.2 ms settle, then swap path
    logic [31:0] sw_cnt_q;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            hp_q <= 1'b0;
            hp_busy_q <= 1'b0;
            sw_cnt_q <= 32'h0;
            speaker_path_sel <= 1'b1;
            headphone_modulator_out <= 1'b1;
        end else begin
            if (hp_chg && !hp_busy_q) begin
                hp_busy_q <= 1'b1;
                // 0.2 ms taken from the millisecond count, so scaled runs scale it too
                sw_cnt_q <= 32'((MS_CYC + 4) / 5);
            end else if (hp_busy_q && volume_level == 16'h0) begin
                if (sw_cnt_q != 32'h0) begin
                    sw_cnt_q <= sw_cnt_q - 32'h1;
                end else begin
                    hp_q <= hp_s;
                    hp_busy_q <= 1'b0;
                    speaker_path_sel <= !hp_s;
                    headphone_modulator_out <= !(hp_dis_q && !hp_s);
                end
            end
        end
    end

    // power-stage enable and bridge enable
    wire running = (st_q == acps_pkg::ACPS_RUN);
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            power_stage_en <= 1'b0;
            bridge_out_en <= 1'b0;
        end else begin
            power_stage_en <= running && (st_d == acps_pkg::ACPS_RUN) && !flt_hold_q && flt_s;
            bridge_out_en <= running && flt_s && !flt_hold_q;
        end
    end

    // register writes; a start write also arms the run wait
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rate_q <= 2'(acps_pkg::ACPS_FS_NORMAL);
            hold_ms_q <= `ACPS_HOLD_RST;
            ramp_steps_q <= `ACPS_RAMP_RST;
            hp_dis_q <= 1'b0;
        end else begin
            if (wr_ctrl) rate_q <= reg_wdata[5:4];
            if (wr_hold) hold_ms_q <= reg_wdata[7:0];
            if (wr_ramp) ramp_steps_q <= reg_wdata[15:0];
            if (wr_hp) hp_dis_q <= reg_wdata[`ACPS_HP_DIS_BIT];
        end
    end

    // read mux, data one cycle after strobe; unmapped reads zero
    logic [31:0] rd_mux;
    assign rd_mux = (reg_addr == `ACPS_REG_CTRL) ? {26'h0, rate_q, 3'h0, start_cmd_q} :
                    (reg_addr == `ACPS_REG_HOLD) ? {24'h0, hold_ms_q} :
                    (reg_addr == `ACPS_REG_RAMP) ? {16'h0, ramp_steps_q} :
                    (reg_addr == `ACPS_REG_HPCFG) ? {27'h0, hp_dis_q, 4'h0} :
                    (reg_addr == `ACPS_REG_STAT) ? {volume_level, 9'h0, st_q, hp_busy_q, flt_hold_q,
                        power_stage_en} : 32'h0;
    always_ff @(posedge clk_sys) begin
        if (!rstn) reg_rdata <= 32'h0;
        else reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
endmodule : acps_top

//--- test/acps_sva.sv
// port assertions of the control-pin sequencer
`timescale 1ns/100ps
module acps_sva #(
    parameter int MS_CYC = 10
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // control pins and register port
    input wire logic device_reset_n,
    input wire logic power_down_in_n,
    input wire logic backend_fault_n,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // power stage and bridge
    input wire logic power_stage_en,
    input wire logic bridge_out_en
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    rst_en_low_a: assert property ($fell(device_reset_n) && power_down_in_n && power_stage_en
        |-> ##[1:5] !power_stage_en) else $error("enable kept after reset pin");
    fault_bridge_a: assert property ($fell(backend_fault_n) |-> ##[1:5] !bridge_out_en)
        else $error("bridge not forced low");
    fault_hold_a: assert property ((!backend_fault_n) [*5] |-> !bridge_out_en)
        else $error("bridge on during fault");
    // eight cycles only: the hold is at least one scaled millisecond
    hold_after_a: assert property ($rose(backend_fault_n) |=> (!bridge_out_en) [*8])
        else $error("bridge recovered early");
    pdn_en_low_a: assert property ($fell(power_down_in_n) && device_reset_n |-> ##[1:5] !power_stage_en)
        else $error("enable kept after power-down");
    pins_off_a: assert property ((!device_reset_n || !power_down_in_n) [*6] |-> !power_stage_en)
        else $error("enable high while held off");
    en_gap_a: assert property ($rose(power_stage_en) |-> $past(power_stage_en, 8) == 1'b0)
        else $error("enable rose without start-up delay");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
endmodule : acps_sva
bind acps_top acps_sva #(.MS_CYC(MS_CYC)) u_acps_sva (.clk_sys, .rstn, .device_reset_n, .power_down_in_n,
    .backend_fault_n, .reg_rd, .reg_rdata, .power_stage_en, .bridge_out_en);

//--- test/acps_ctrl_model.sv
// system controller model driving the amplifier control pins
`timescale 1ns/100ps
module acps_ctrl_model (
    // clock
    input wire logic clk_sys,
    // control pins, reset pin low from power-on
    output logic device_reset_n = 1'b0,
    output logic power_down_in_n = 1'b1,
    output logic backend_fault_n = 1'b1,
    output logic headphone_select = 1'b0
);
    // reset pin low for n cycles, one scaled millisecond
    task automatic reset_pulse(input int n);
        @(posedge clk_sys);
        device_reset_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        device_reset_n <= 1'b1;
    endtask : reset_pulse
    // callers keep n above 44 cycles
    task automatic fault_pulse(input int n);
        @(posedge clk_sys);
        backend_fault_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        backend_fault_n <= 1'b1;
    endtask : fault_pulse
    // levels stand until the next call; the bench spaces calls beyond 100 cycles
    task automatic set_pins(input logic pdn_n, input logic hp);
        @(posedge clk_sys);
        power_down_in_n <= pdn_n;
        headphone_select <= hp;
    endtask : set_pins
endmodule : acps_ctrl_model

//--- test/testbench.sv
// self-checking bench of the control-pin sequencer
`timescale 1ns/100ps
module testbench;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} acps_row_t;
    localparam int RUN = 20;
    localparam int STARTUP = 30;
    localparam int MS = 10;
    logic clk_sys = 1'b0, rstn = 1'b0, mute = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic device_reset_n, power_down_in_n, backend_fault_n, headphone_select, frame_clk;
    logic power_stage_en, bridge_out_en, headphone_modulator_out, speaker_path_sel;
    logic [2:0] fcnt = 3'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
    logic [15:0] volume_level;
    int failures = 0;
    int n_compared = 0;
    int t;
    acps_row_t rows [8] = '{'{1'b0, 8'h1c, 32'h0, 32'h1}, '{1'b0, 8'h20, 32'h0, 32'h400},
        '{1'b1, 8'h1c, 32'h2, 32'h0}, '{1'b0, 8'h1c, 32'h0, 32'h2}, '{1'b1, 8'h20, 32'h8, 32'h0},
        '{1'b0, 8'h20, 32'h0, 32'h8}, '{1'b1, 8'h40, 32'hff, 32'h0}, '{1'b0, 8'h40, 32'h0, 32'h0}};
    acps_top #(.RUN_CYC(RUN), .PDN_VALID_CYC(10), .STARTUP_CYC(STARTUP), .MS_CYC(MS)) dut (.clk_sys, .rstn,
        .device_reset_n, .power_down_in_n, .backend_fault_n, .headphone_select, .mute, .frame_clk, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_stage_en, .bridge_out_en, .headphone_modulator_out,
        .speaker_path_sel, .volume_level);
    acps_ctrl_model ctl (.clk_sys, .device_reset_n, .power_down_in_n, .backend_fault_n, .headphone_select);
    initial forever #4 clk_sys = ~clk_sys;
    // frame clock of eight core cycles keeps the ramp runs short
    always @(posedge clk_sys) fcnt <= fcnt + 3'h1;
    assign frame_clk = fcnt[2];
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cyc
    task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : reg_access
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        ctl.reset_pulse(MS);
        foreach (rows[i]) begin
            reg_access(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) check(rd, rows[i].e, "register");
        end
        $display("register test done");
        reg_access(1'b1, 8'h00, 32'h1);
        wait_cyc(RUN - 6);
        check(32'(power_stage_en), 32'h0, "run early");
        wait_cyc(20);
        reg_access(1'b0, 8'h28, 32'h0);
        check(32'({rd[0], power_stage_en}), 32'h3, "running");
        $display("start test done");
        ctl.fault_pulse(50);
        wait_cyc(12);
        check(32'(bridge_out_en), 32'h0, "fault hold");
        wait_cyc(30);
        check(32'(bridge_out_en), 32'h1, "recovery");
        $display("fault test done");
        for (int r = 2; r >= 0; r--) begin
            reg_access(1'b1, 8'h00, r << 4);
            t = 256 << r;
            @(posedge clk_sys);
            mute <= 1'b0;
            wait_cyc(t + 40);
            check(32'(volume_level), 32'h8, "ramp top");
            @(posedge clk_sys);
            mute <= 1'b1;
            wait_cyc(t * 3 / 4);
            check(32'(volume_level != 16'h0), 32'h1, "ramp short");
            wait_cyc(t / 4 + 40);
            check(32'(volume_level), 32'h0, "ramp end");
        end
        $display("mute test done");
        @(posedge clk_sys);
        mute <= 1'b0;
        wait_cyc(300);
        for (int i = 0; i < 4; i++) begin
            if (i == 2) reg_access(1'b1, 8'h24, 32'h10);
            ctl.set_pins(1'b1, !i[0]);
            wait_cyc(10);
            check(32'(speaker_path_sel), 32'(!i[0]), "switch early");
            wait_cyc(700);
            check(32'({speaker_path_sel, headphone_modulator_out}), 32'({i[0], i != 3}), "switch");
        end
        $display("headphone test done");
        ctl.set_pins(1'b0, 1'b0);
        wait_cyc(20);
        check(32'(power_stage_en), 32'h0, "down");
        ctl.reset_pulse(MS);
        wait_cyc(80);
        ctl.set_pins(1'b1, 1'b0);
        wait_cyc(STARTUP - 8);
        check(32'(power_stage_en), 32'h0, "startup early");
        wait_cyc(20);
        check(32'(power_stage_en), 32'h1, "back up");
        $display("power-down test done");
        ctl.reset_pulse(MS);
        wait_cyc(10);
        check(32'(power_stage_en), 32'h0, "reset");
        reg_access(1'b1, 8'h00, 32'h1);
        wait_cyc(RUN + 10);
        check(32'(power_stage_en), 32'h1, "restart");
        $display("reset test done");
        finish_test();
    end
endmodule : testbench
